// ### asf_pkg.sv
package asf_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ          = 50_000_000;  // pclk rate
  localparam int unsigned STALE_TIME_S    = 10;          // no-new-value window, seconds
  localparam int unsigned STATIC_TIME_S   = 60;          // static malfunction must outlast this
  localparam int unsigned AVG_SHORT_S     = 10;          // averaging time threshold, seconds
  localparam int unsigned STALE_CYCLES    = STALE_TIME_S * CLK_HZ;
  localparam int unsigned STATIC_CYCLES   = STATIC_TIME_S * CLK_HZ;

  // register offsets (byte addresses)
  localparam logic [11:0] ADDR_CTRL       = 12'h000;  // averaging time, heating inputs
  localparam logic [11:0] ADDR_FILL       = 12'h004;  // buffer capacity and occupancy
  localparam logic [11:0] ADDR_VEND       = 12'h008;  // vendor status byte
  localparam logic [11:0] ADDR_TELE       = 12'h00C;  // telemetry op / error bytes
  localparam logic [11:0] ADDR_COND       = 12'h010;  // live condition flags
  localparam logic [11:0] ADDR_SNAP       = 12'h014;  // snapshot strobe (write)

  // control register fields
  localparam int unsigned CTRL_AVG_LSB    = 0;   // averaging time in s, 16 bits
  localparam int unsigned CTRL_HCRIT_BIT  = 16;  // heating switch-on criterion
  localparam int unsigned CTRL_HON_BIT    = 17;  // heating switched on
  localparam int unsigned CTRL_VTL_BIT    = 18;  // virtual_temperature_limit violated
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;

  // vendor byte bit positions
  localparam int unsigned VB_GEN          = 0;
  localparam int unsigned VB_FILL_LSB     = 1;
  localparam int unsigned VB_STATIC       = 5;
  localparam int unsigned VB_HCRIT        = 6;
  localparam int unsigned VB_HON          = 7;
  // telemetry operating byte positions
  localparam int unsigned TO_FILL_LSB     = 1;
  localparam int unsigned TO_HCRIT        = 5;
  localparam int unsigned TO_HON          = 6;
  // telemetry error byte positions
  localparam int unsigned TE_GEN          = 0;
  localparam int unsigned TE_STATIC       = 1;

  // condition bundle shared by all status bytes
  typedef struct packed {
    logic       gen_fault;     // general malfunction
    logic [2:0] fill_code;     // eighth-step fill level
    logic       static_fault;  // static malfunction
    logic       heat_crit;     // heating criterion
    logic       heat_on;       // heating on
  } asf_cond_s;

  // the three published bytes
  typedef struct packed {
    logic [7:0] vendor;
    logic [7:0] tele_op;
    logic [7:0] tele_err;
  } asf_status_s;

endpackage

// ### asf_formatter.sv
// Function
// R1: vendor byte built from extended-status conditions
// R2: short averaging: fault after 10 s stale
// R3: long averaging: fault when buffer under half
// R4: fill code in bits 1-3, bit 4 zero
// R5: vendor bit 5 static fault over one minute
// R6: vendor bit 6 follows heating criterion
// R7: vendor bit 7 follows heating on
// R8: separate telemetry operating and error bytes
// R9: telemetry op bit 0 zero, fill in 1-3
// R10: telemetry op bit 5 criterion, 4,7 zero
// R11: telemetry op bit 6 heating on
// R12: telemetry error bits 0,1 faults, rest zero
// R13: all bytes from one coherent snapshot
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module asf_formatter
  import asf_pkg::*;
#(
  parameter int unsigned STALE_CYC  = STALE_CYCLES,   // 10 s at pclk
  parameter int unsigned STATIC_CYC = STATIC_CYCLES   // 60 s at pclk
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // measurement events from the acquisition logic (same clock)
  input  wire logic        meas_valid,
  // telegram side
  input  wire logic        telegram_req,
  output asf_status_s      status,
  output logic             status_valid
);

  // live condition registers
  logic [31:0] ctrl_r;           // averaging time and heating inputs
  logic [15:0] fill_cap_r;       // buffer capacity in values
  logic [15:0] fill_cnt_r;       // values currently in buffer
  logic [31:0] stale_cnt_r;      // cycles since last new value
  logic [31:0] static_cnt_r;     // cycles the static cause has lasted
  logic        stale_r;          // no new value for 10 s
  logic        static_r;         // static malfunction latched state
  asf_status_s snap_r;           // published snapshot
  logic        snap_vld_r;       // one-cycle snapshot strobe
  asf_cond_s   cond;             // combinational condition bundle
  logic        short_avg;        // averaging time below 10 s
  logic        low_fill;         // buffer under 50 %
  logic [2:0]  fill_code;        // eighth-step code
  logic        wr_en;            // apb write access phase
  logic        rd_ok;            // decoded address hit
  logic        snap_wr;          // software snapshot request
  logic [31:0] fill_x8;          // occupancy times eight
  logic [31:0] cap_x1;           // capacity, widened

  assign wr_en   = psel && penable && pwrite;
  assign snap_wr = wr_en && (paddr == ADDR_SNAP);
  assign pready  = 1'b1;         // zero wait states keep the master simple
  assign short_avg = ctrl_r[CTRL_AVG_LSB +: 16] < 16'(AVG_SHORT_S);

  // apb writes, byte enables honoured for control word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r     <= CTRL_RESET;
      fill_cap_r <= 16'h0001;
    end
    else if (wr_en && paddr == ADDR_CTRL)
    begin
      for (int i = 0; i < 4; i++)
        if (pstrb[i])
          ctrl_r[i*8 +: 8] <= pwdata[i*8 +: 8];
    end
    else if (wr_en && paddr == ADDR_FILL && pstrb[3:2] == 2'b11)
    begin
      // capacity zero would divide nothing; clamp to one
      fill_cap_r <= (pwdata[31:16] == 16'h0000) ? 16'h0001 : pwdata[31:16];
    end
  end

  // buffer occupancy: one value added per new measurement up to capacity, software may reload
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fill_cnt_r <= 16'h0000;
    else if (wr_en && paddr == ADDR_FILL && pstrb[1:0] == 2'b11)
      fill_cnt_r <= pwdata[15:0];
    else if (meas_valid && fill_cnt_r < fill_cap_r)
      fill_cnt_r <= fill_cnt_r + 16'h0001;
  end

  // stale timer: restarts on every new value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stale_cnt_r <= 32'h0000_0000;
      stale_r     <= 1'b0;
    end
    else if (meas_valid)
    begin
      stale_cnt_r <= 32'h0000_0000;
      stale_r     <= 1'b0;
    end
    else if (stale_cnt_r >= STALE_CYC - 1)
      stale_r <= 1'b1;           // R2
    else
      stale_cnt_r <= stale_cnt_r + 32'h0000_0001;
  end

  // fraction tests by cross multiplication, no divider needed
  assign fill_x8 = {13'h0000, fill_cnt_r, 3'h0};
  assign cap_x1  = {16'h0000, fill_cap_r};
  assign low_fill = ({15'h0000, fill_cnt_r, 1'b0} < cap_x1);  // R3

  // code n means n/8 < x <= (n+1)/8; empty buffer reads code 0
  always_comb
  begin
    fill_code = 3'h0;
    for (int n = 1; n < 8; n++)
      if (fill_x8 > cap_x1 * 32'(n))
        fill_code = 3'(n);       // R4
  end

  // static malfunction: cause must last more than one minute
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      static_cnt_r <= 32'h0000_0000;
      static_r     <= 1'b0;
    end
    else if (!(ctrl_r[CTRL_VTL_BIT] || stale_r))
    begin
      static_cnt_r <= 32'h0000_0000;
      static_r     <= 1'b0;
    end
    else if (static_cnt_r >= STATIC_CYC)
      static_r <= 1'b1;          // R5
    else
      static_cnt_r <= static_cnt_r + 32'h0000_0001;
  end

  // one condition bundle feeds every byte, so they cannot disagree
  always_comb
  begin
    cond.gen_fault    = short_avg ? stale_r : low_fill;  // R1 R2 R3
    cond.fill_code    = fill_code;
    cond.static_fault = static_r;
    cond.heat_crit    = ctrl_r[CTRL_HCRIT_BIT];
    cond.heat_on      = ctrl_r[CTRL_HON_BIT];
  end

  // snapshot all three bytes in one edge per telegram
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snap_r     <= '0;
      snap_vld_r <= 1'b0;
    end
    else
    begin
      snap_vld_r <= telegram_req || snap_wr;
      if (telegram_req || snap_wr)   // R13
      begin
        snap_r.vendor                    <= 8'h00;
        snap_r.vendor[VB_GEN]            <= cond.gen_fault;
        snap_r.vendor[VB_FILL_LSB +: 3]  <= cond.fill_code;      // R4
        snap_r.vendor[VB_STATIC]         <= cond.static_fault;   // R5
        snap_r.vendor[VB_HCRIT]          <= cond.heat_crit;      // R6
        snap_r.vendor[VB_HON]            <= cond.heat_on;        // R7
        snap_r.tele_op                   <= 8'h00;               // R8
        snap_r.tele_op[TO_FILL_LSB +: 3] <= cond.fill_code;      // R9
        snap_r.tele_op[TO_HCRIT]         <= cond.heat_crit;      // R10
        snap_r.tele_op[TO_HON]           <= cond.heat_on;        // R11
        snap_r.tele_err                  <= 8'h00;
        snap_r.tele_err[TE_GEN]          <= cond.gen_fault;      // R12
        snap_r.tele_err[TE_STATIC]       <= cond.static_fault;   // R12
      end
    end
  end

  assign status       = snap_r;
  assign status_valid = snap_vld_r;

  // apb read mux; unmapped addresses answer with an error
  always_comb
  begin
    prdata = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (paddr)
      ADDR_CTRL: prdata = ctrl_r;
      ADDR_FILL: prdata = {fill_cap_r, fill_cnt_r};
      ADDR_VEND: prdata = {24'h00_0000, snap_r.vendor};
      ADDR_TELE: prdata = {16'h0000, snap_r.tele_err, snap_r.tele_op};
      ADDR_COND: prdata = {25'h000_0000, cond};  // seven live flags, zero above
      ADDR_SNAP: prdata = 32'h0000_0000;
      default:   rd_ok  = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !rd_ok;

  // ---- assertions ----
  sequence s_snap_taken;
    (telegram_req || snap_wr) ##1 status_valid;
  endsequence

  a_vendor_zero_bit: assert property (@(posedge pclk) disable iff (!presetn)
    status.vendor[4] == 1'b0) else $error("vendor bit 4 not zero"); // R4
  a_tele_op_zero: assert property (@(posedge pclk) disable iff (!presetn)
    status.tele_op[0] == 1'b0 && status.tele_op[4] == 1'b0 && status.tele_op[7] == 1'b0)
    else $error("telemetry op reserved bit set"); // R10
  a_tele_err_zero: assert property (@(posedge pclk) disable iff (!presetn)
    status.tele_err[7:2] == 6'h00) else $error("telemetry error upper bits set"); // R12
  a_fill_agree: assert property (@(posedge pclk) disable iff (!presetn)
    status.vendor[3:1] == status.tele_op[3:1]) else $error("fill codes disagree"); // R9
  a_fault_agree: assert property (@(posedge pclk) disable iff (!presetn)
    status.vendor[VB_GEN] == status.tele_err[TE_GEN] && status.vendor[VB_STATIC] == status.tele_err[TE_STATIC])
    else $error("fault bits disagree"); // R1
  a_heat_crit_snap: assert property (@(posedge pclk) disable iff (!presetn)
    (telegram_req || snap_wr) |=> status.vendor[VB_HCRIT] == $past(ctrl_r[CTRL_HCRIT_BIT])
      && status.tele_op[TO_HCRIT] == $past(ctrl_r[CTRL_HCRIT_BIT]))
    else $error("heating criterion not captured"); // R6
  a_heat_on_snap: assert property (@(posedge pclk) disable iff (!presetn)
    s_snap_taken |-> status.vendor[VB_HON] == status.tele_op[TO_HON]
      && status.vendor[VB_HON] == $past(ctrl_r[CTRL_HON_BIT]))
    else $error("heating on not captured"); // R7
  a_stable_between: assert property (@(posedge pclk) disable iff (!presetn)
    !(telegram_req || snap_wr) |=> $stable(status)) else $error("status changed without snapshot"); // R13
  a_stale_gen: assert property (@(posedge pclk) disable iff (!presetn)
    (short_avg && stale_r && !meas_valid) |-> cond.gen_fault) else $error("stale fault missing"); // R2
  a_low_fill_gen: assert property (@(posedge pclk) disable iff (!presetn)
    (!short_avg) |-> cond.gen_fault == (2 * fill_cnt_r < fill_cap_r)) else $error("half fill test wrong"); // R3
  a_static_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(static_r) |-> static_cnt_r >= STATIC_CYC) else $error("static set too early"); // R5

  // every request, from the logger or from software, yields exactly one strobe
  a_valid_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (telegram_req || snap_wr) |=> status_valid) else $error("snapshot strobe missing"); // R13
  a_valid_alone: assert property (@(posedge pclk) disable iff (!presetn)
    !(telegram_req || snap_wr) |=> !status_valid) else $error("stray snapshot strobe"); // R13

  // a full buffer must report the top eighth, an empty one the bottom
  a_fill_full: assert property (@(posedge pclk) disable iff (!presetn)
    (fill_cnt_r >= fill_cap_r) |-> cond.fill_code == 3'h7) else $error("full buffer code wrong"); // R4
  a_fill_empty: assert property (@(posedge pclk) disable iff (!presetn)
    (fill_cnt_r == 16'h0000) |-> cond.fill_code == 3'h0) else $error("empty buffer code wrong"); // R4

endmodule

// ### asf_host.sv
`timescale 1ns/1ps
// data logger model: asks for a telegram and keeps the bytes it reports
module asf_host
  import asf_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bench side
  input  wire logic        ask,
  output asf_status_s      last,
  output logic             got,
  // formatter side
  output logic             telegram_req,
  input  wire asf_status_s status,
  input  wire logic        status_valid
);
  // one request pulse per ask, launched one edge after the bench asks
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      telegram_req <= 1'b0;
    else
      telegram_req <= ask;

  // latch bytes only while valid; later changes of status must not leak in
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      last <= '0;
      got  <= 1'b0;
    end
    else
    begin
      got <= status_valid;
      if (status_valid)
        last <= status;
    end
endmodule

// ### asf_formatter_bench.sv
`timescale 1ns/1ps
module asf_formatter_bench
  import asf_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite;  // apb master
  logic [11:0] paddr;                                 // byte address
  logic [31:0] pwdata, prdata, rd;                    // data, last read
  logic [3:0]  pstrb;                                 // byte enables
  logic        pready, pslverr, er;                   // answer, last error
  logic        meas_valid, ask, got, treq, sval;      // events
  asf_status_s status, last;                          // live and latched bytes
  int          err_count, checks_done;                // tallies

  // short counts keep the run small
  asf_formatter #(.STALE_CYC(20), .STATIC_CYC(50)) u_asf_formatter (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid),
    .telegram_req(treq), .status(status), .status_valid(sval));
  asf_host u_asf_host (.pclk(pclk), .presetn(presetn), .ask(ask), .last(last), .got(got),
    .telegram_req(treq), .status(status), .status_valid(sval));

  // free-running 50 MHz clock
  always #10 pclk = ~pclk;

  task wrap_up;
    $display("checks_done=%0d err_count=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e)
    begin
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      err_count++;
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    if (i == 20)
    begin
      chk(0, 1, "apb hang");
      wrap_up;
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // one new measured value; restarts the stale window
  task meas;
    @(posedge pclk) meas_valid <= 1'b1;
    @(posedge pclk) meas_valid <= 1'b0;
  endtask

  // telegram through the logger, then all three bytes against the fields
  task snap(input logic g, input logic [2:0] f, input logic s, input logic c, input logic h, input string m);
    int i;
    @(posedge pclk) ask <= 1'b1;
    @(posedge pclk) ask <= 1'b0;
    for (i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      #1;
      if (got === 1'b1) break;
    end
    if (i == 10)
    begin
      chk(0, 1, "no status");
      wrap_up;
    end
    chk(last.vendor, {h, c, s, 1'b0, f, g}, m);
    chk(last.tele_op, {1'b0, h, c, 1'b0, f, 1'b0}, m);
    chk(last.tele_err, {6'h00, s, g}, m);
  endtask

  task t_reset;
    chk({8'h00, status}, 32'h0000_0000, "status reset");
    apb(0, ADDR_CTRL, 0);
    chk(rd, CTRL_RESET, "ctrl reset");
    apb(0, ADDR_FILL, 0);
    chk(rd, 32'h0001_0000, "fill reset");
    apb(0, 12'h100, 0);
    chk({31'h0, er}, 32'h1, "unmapped");
  endtask

  // every heating combination, then a held snapshot must not follow live inputs
  task t_heat;
    for (int k = 0; k < 4; k++)
    begin
      meas;
      apb(1, ADDR_CTRL, {14'h0, k[1:0], 16'h0001});
      snap(0, 3'h7, 0, k[0], k[1], "heating");
    end
    apb(1, ADDR_CTRL, 32'h0000_0001);
    chk({24'h0, status.vendor}, 32'hCE, "held snapshot");
  endtask

  // long averaging: every eighth of an 8-deep buffer, half is no fault
  task t_fill;
    apb(1, ADDR_CTRL, 32'h0000_0014);
    for (int k = 0; k <= 8; k++)
    begin
      meas;
      apb(1, ADDR_FILL, {16'h0008, 16'(k)});
      snap(k < 4, (k == 0) ? 3'h0 : 3'(k - 1), 0, 0, 0, "fill");
    end
  endtask

  // short averaging at 9 s: stale fault, then static after the long count
  task t_stale;
    apb(1, ADDR_CTRL, 32'h0000_0009);
    meas;
    snap(0, 3'h7, 0, 0, 0, "fresh");
    repeat (25) @(posedge pclk);
    snap(1, 3'h7, 0, 0, 0, "stale");
    repeat (60) @(posedge pclk);
    snap(1, 3'h7, 1, 0, 0, "static stale");
    meas;
    snap(0, 3'h7, 0, 0, 0, "recovered");
  endtask

  // lasting temperature-limit violation with fresh values
  task t_static;
    apb(1, ADDR_CTRL, 32'h0004_0009);
    repeat (9)
    begin
      meas;
      repeat (8) @(posedge pclk);
    end
    snap(0, 3'h7, 1, 0, 0, "limit static");
    // software snapshot path, then the register view of the same bytes
    meas;
    apb(1, ADDR_SNAP, 0);
    apb(0, ADDR_COND, 0);
    chk(rd, 32'h0000_003C, "live cond");
    apb(0, ADDR_VEND, 0);
    chk(rd, 32'h0000_002E, "vendor reg");
    apb(0, ADDR_TELE, 0);
    chk(rd, 32'h0000_020E, "tele reg");
  endtask

  initial
  begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0;
    pwdata = 0; pstrb = 4'hF; meas_valid = 0; ask = 0; err_count = 0; checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_heat;
    t_fill;
    t_stale;
    t_static;
    wrap_up;
  end
endmodule
